// *** wtdhc_top.sv ***
// host control, time code decoder, servo and switch logic of the wobble time decoder
`timescale 1ns/1ps
`default_nettype none
module wtdhc_top #(
  parameter int REF_HALF_N = wtdhc_pkg::REF_HALF_NORM,
  parameter int REF_HALF_D = wtdhc_pkg::REF_HALF_DBL,
  parameter int FRAME_LEN = wtdhc_pkg::FRAME_LEN
) (
  input wire logic I_REF_CLK,
  input wire logic I_RESET_N,
  input wire logic I_IFACE_TYPE_SEL,
  input wire logic I_CHIP_EN,
  input wire logic I_SERIAL_BIT_CLK,
  input wire logic I_SERIAL_IN,
  output logic O_SERIAL_OUT,
  input wire logic I_BIPHASE_CLK_IN,
  input wire logic I_BIPHASE_DATA_IN,
  input wire logic I_CARRIER_CLK_IN,
  input wire logic I_COARSE_CLK_IN,
  input wire logic I_SERVO_REF_IN,
  input wire logic I_SERVO_SRC_SEL,
  input wire logic I_OUT_STYLE_SEL,
  input wire logic I_SWITCH_PIN_CTL,
  input wire logic I_SW_A_IN0,
  input wire logic I_SW_A_IN1,
  input wire logic I_SW_B_IN0,
  input wire logic I_SW_B_IN1,
  output logic O_TIME_SYNC_OUT,
  output logic [23:0] O_TIME_DATA,
  output logic O_CRC_OK,
  output logic O_SERVO_REF_OUT,
  output logic O_LOCK,
  output logic O_MOTOR_CTL_POS,
  output logic O_MOTOR_CTL_NEG,
  output logic O_MOTOR_CTL_NEG_OE,
  output logic O_SW_A_OUT,
  output logic O_SW_B_OUT,
  output logic O_SW_B_OUT1,
  output logic O_SW_B_OUT1_OE
);
  localparam int CW = wtdhc_pkg::CNT_W;

  // link side: frame progress, cleared whenever chip enable is low
  typedef struct packed {
    logic [5:0] cnt;
    logic [7:0] sh;
    logic cmd_ok;
    logic rd;
    logic [4:0] idx;
  } wtdhc_lnk_t;
  // link side: captured command and its event toggle, kept across frames
  typedef struct packed {
    logic [7:0] cmd;
    logic tog;
  } wtdhc_lcap_t;

  typedef struct packed {
    logic [wtdhc_pkg::NPIN-1:0] s1;
    logic [wtdhc_pkg::NPIN-1:0] s2;
    logic bclk_d;
    logic sclk_d;
    logic ref_d;
    logic tog_seen;
    logic [3:0] core;
    logic sw_reg;
    logic [3:0] msel;
    logic [24:0] out_word;
    wtdhc_pkg::wtdhc_dec_t dec;
    logic [7:0] hist;
    logic [5:0] bcnt;
    logic [23:0] dsh;
    logic [13:0] crc;
    logic [23:0] time_word;
    logic crc_ok;
    logic sync_p;
    logic [CW-1:0] div;
    logic ref_o;
    logic [CW-1:0] rcnt;
    logic [CW-1:0] rper;
    logic [CW-1:0] icnt;
    logic [CW-1:0] iper;
    logic up;
    logic dn;
    logic lock;
    logic pos;
    logic neg;
    logic neg_oe;
    logic a_out;
    logic b_out;
    logic b1_out;
    logic b1_oe;
  } wtdhc_main_t;

  wtdhc_lnk_t lnk, next_lnk;
  wtdhc_lcap_t lcap, next_lcap;
  wtdhc_main_t st, next_st, rst_st;
  logic link_rst_n;
  logic [wtdhc_pkg::NPIN-1:0] pins;
  logic [5:0] base;
  logic [7:0] byte_in;
  logic bit_in;
  logic [7:0] hist_n;
  logic fb;
  logic [13:0] crc_n;
  logic sclk;
  logic slow;
  logic [23:0] diff_x100;
  logic [23:0] tol;
  logic sw_hi;
  logic [CW-1:0] half;

  // frame state clears with chip enable low, since the link clock stops between frames
  assign link_rst_n = I_RESET_N & I_CHIP_EN;

  // link side shifting and address matching
  always_comb begin
    next_lnk = lnk;
    next_lcap = lcap;
    base = I_IFACE_TYPE_SEL ? 6'(wtdhc_pkg::ADDR_BITS) : 6'h00;
    byte_in = {I_SERIAL_IN, lnk.sh[7:1]}; // lsb first
    next_lnk.sh = byte_in;
    if (lnk.cnt != 6'h3F) begin
      next_lnk.cnt = lnk.cnt + 6'h01;
    end
    if ((lnk.rd || !I_IFACE_TYPE_SEL) && lnk.idx != 5'h1F) begin
      next_lnk.idx = lnk.idx + 5'h01;
    end
    if (I_IFACE_TYPE_SEL && lnk.cnt == 6'(wtdhc_pkg::ADDR_BITS - 1)) begin
      next_lnk.cmd_ok = (byte_in == wtdhc_pkg::ADDR_CMD);
      next_lnk.rd = (byte_in == wtdhc_pkg::ADDR_OUT);
    end
    if (lnk.cnt == base + 6'(wtdhc_pkg::CMD_BITS - 1) && (lnk.cmd_ok || !I_IFACE_TYPE_SEL)) begin
      next_lcap.cmd = byte_in;
      next_lcap.tog = ~lcap.tog;
    end
  end

  // frame progress, sampled on link clock rising edges while enabled
  always_ff @(posedge I_SERIAL_BIT_CLK or negedge link_rst_n) begin
    if (!link_rst_n) begin
      lnk <= '0;
    end else begin
      lnk <= next_lnk;
    end
  end

  // captured command survives the end of the frame for the main side
  always_ff @(posedge I_SERIAL_BIT_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      lcap <= '0;
    end else begin
      lcap <= next_lcap;
    end
  end

  // output word is frozen by the main side while a frame runs
  assign O_SERIAL_OUT = (lnk.rd || (!I_IFACE_TYPE_SEL && I_CHIP_EN)) ? st.out_word[lnk.idx] : 1'b0;

  // all main-side pin inputs and the link toggle pass two flip-flops; type select and the link pins do not
  assign pins = {lcap.tog, I_CHIP_EN, I_SW_B_IN1, I_SW_B_IN0, I_SW_A_IN1, I_SW_A_IN0, I_SWITCH_PIN_CTL,
    I_OUT_STYLE_SEL, I_SERVO_SRC_SEL, I_SERVO_REF_IN, I_COARSE_CLK_IN, I_CARRIER_CLK_IN,
    I_BIPHASE_DATA_IN, I_BIPHASE_CLK_IN};

  // reset image of the main state
  always_comb begin
    rst_st = '0;
    rst_st.core = wtdhc_pkg::CORE_RST_VAL;
    rst_st.sw_reg = wtdhc_pkg::SWITCH_RST_VAL;
    rst_st.msel = wtdhc_pkg::MONITOR_RST_VAL;
    rst_st.dec = wtdhc_pkg::DEC_HUNT;
    rst_st.neg_oe = 1'b1;
  end

  // main side next state
  always_comb begin
    next_st = st;
    next_st.s1 = pins;
    next_st.s2 = st.s1;
    next_st.bclk_d = st.s2[wtdhc_pkg::P_BCLK];
    sclk = st.s2[wtdhc_pkg::P_SRC] ? st.s2[wtdhc_pkg::P_COARSE] : st.s2[wtdhc_pkg::P_CARR];
    next_st.sclk_d = sclk;
    next_st.ref_d = st.s2[wtdhc_pkg::P_REF];
    next_st.sync_p = 1'b0;
    bit_in = st.s2[wtdhc_pkg::P_BDAT];
    hist_n = {st.hist[6:0], bit_in};
    fb = bit_in ^ st.crc[13];
    crc_n = {st.crc[12:0], 1'b0} ^ (fb ? wtdhc_pkg::CRC_POLY : 14'h0000);

    // command applied only after the frame has ended
    if (st.s2[wtdhc_pkg::P_TOG] != st.tog_seen && !st.s2[wtdhc_pkg::P_CE]) begin
      next_st.tog_seen = st.s2[wtdhc_pkg::P_TOG];
      case (lcap.cmd[7:4])
        wtdhc_pkg::SEL_CORE: next_st.core = lcap.cmd[3:0];
        wtdhc_pkg::SEL_SWITCH: next_st.sw_reg = lcap.cmd[0];
        wtdhc_pkg::SEL_MONITOR: next_st.msel = lcap.cmd[3:0];
        default: next_st.tog_seen = st.s2[wtdhc_pkg::P_TOG]; // test data and others ignored
      endcase
    end

    // monitor word reloads only between frames so the link sees it still
    if (!st.s2[wtdhc_pkg::P_CE]) begin
      case (st.msel)
        wtdhc_pkg::MON_STATUS: next_st.out_word = {17'h00000, st.core[wtdhc_pkg::CORE_SOFT_RST], 6'h00,
          st.crc_ok};
        wtdhc_pkg::MON_CRC_TIME: next_st.out_word = {st.time_word, st.crc_ok};
        wtdhc_pkg::MON_TIME: next_st.out_word = {1'b0, st.time_word};
        default: next_st.out_word = 25'h0000000;
      endcase
    end

    // time code decoder, stepped on biphase clock rising edges
    if (st.s2[wtdhc_pkg::P_BCLK] && !st.bclk_d) begin
      next_st.hist = hist_n;
      case (st.dec)
        wtdhc_pkg::DEC_HUNT: begin
          if (hist_n == wtdhc_pkg::SYNC_PAT) begin
            next_st.dec = wtdhc_pkg::DEC_TRACK;
            next_st.bcnt = 6'h00;
            next_st.crc = 14'h0000;
            next_st.sync_p = 1'b1;
          end
        end
        wtdhc_pkg::DEC_TRACK: begin
          next_st.bcnt = st.bcnt + 6'h01;
          if (st.bcnt < 6'(wtdhc_pkg::FRAME_DATA)) begin
            next_st.crc = crc_n;
            if (st.bcnt < 6'(wtdhc_pkg::TIME_BITS)) begin
              next_st.dsh = {st.dsh[22:0], bit_in};
            end
            if (st.bcnt == 6'(wtdhc_pkg::FRAME_DATA - 1)) begin
              next_st.time_word = st.dsh;
              next_st.crc_ok = (crc_n == 14'h0000);
            end
          end else if (hist_n == wtdhc_pkg::SYNC_PAT) begin
            next_st.bcnt = 6'h00;
            next_st.crc = 14'h0000;
            next_st.sync_p = 1'b1;
          end else if (st.bcnt >= 6'(FRAME_LEN - 1)) begin
            // a missed sync is filled in only with protection on
            if (st.core[wtdhc_pkg::CORE_GUARD]) begin
              next_st.bcnt = 6'h00;
              next_st.crc = 14'h0000;
              next_st.sync_p = 1'b1;
            end else begin
              next_st.dec = wtdhc_pkg::DEC_HUNT;
            end
          end
        end
        default: next_st.dec = wtdhc_pkg::DEC_HUNT;
      endcase
    end
    if (st.core[wtdhc_pkg::CORE_SYNC_CLR]) begin
      next_st.dec = wtdhc_pkg::DEC_HUNT;
      next_st.hist = 8'h00;
      next_st.bcnt = 6'h00;
      next_st.sync_p = 1'b0;
    end

    // reference divider, half period follows the speed bit
    half = st.core[wtdhc_pkg::CORE_DBL] ? CW'(REF_HALF_D) : CW'(REF_HALF_N);
    if (st.div >= half - CW'(1)) begin
      next_st.div = '0;
      next_st.ref_o = ~st.ref_o;
    end else begin
      next_st.div = st.div + CW'(1);
    end

    // period measurement of reference and selected input, saturating
    if (st.rcnt != '1) begin
      next_st.rcnt = st.rcnt + CW'(1);
    end
    if (st.icnt != '1) begin
      next_st.icnt = st.icnt + CW'(1);
    end
    if (st.s2[wtdhc_pkg::P_REF] && !st.ref_d) begin
      next_st.rper = st.rcnt;
      next_st.rcnt = '0;
      next_st.up = 1'b1;
    end
    if (sclk && !st.sclk_d) begin
      next_st.iper = st.icnt;
      next_st.icnt = '0;
      next_st.dn = 1'b1;
    end
    // phase detector: whichever edge comes first holds until the other arrives
    if (next_st.up && next_st.dn) begin
      next_st.up = 1'b0;
      next_st.dn = 1'b0;
    end

    // lock when periods agree within the tolerance
    diff_x100 = (st.iper > st.rper) ? 24'(st.iper - st.rper) * 24'd100 : 24'(st.rper - st.iper) * 24'd100;
    tol = 24'(st.rper) * 24'(wtdhc_pkg::LOCK_PCT);
    next_st.lock = (st.rper != '0) && (diff_x100 <= tol);
    slow = st.iper > st.rper; // longer input period means velocity too low
    if (!st.s2[wtdhc_pkg::P_STYLE]) begin
      next_st.neg_oe = 1'b1;
      if (st.lock) begin
        next_st.pos = st.up;
        next_st.neg = st.dn;
      end else begin
        next_st.pos = slow;
        next_st.neg = ~slow;
      end
    end else begin
      next_st.neg = st.up;
      next_st.neg_oe = st.up | st.dn;
      next_st.pos = st.icnt < (st.rper >> 1);
    end

    // switches; sources pass through the synchronisers
    sw_hi = st.s2[wtdhc_pkg::P_SWPIN] & st.sw_reg;
    next_st.a_out = sw_hi ? st.s2[wtdhc_pkg::P_AI1] : st.s2[wtdhc_pkg::P_AI0];
    next_st.b_out = sw_hi ? st.s2[wtdhc_pkg::P_AI1] : st.s2[wtdhc_pkg::P_BI0];
    next_st.b1_out = sw_hi & st.s2[wtdhc_pkg::P_BI1];
    next_st.b1_oe = sw_hi;

    // soft reset holds all but the command registers, synchronisers, edge detectors, monitor word and switch outputs
    if (st.core[wtdhc_pkg::CORE_SOFT_RST]) begin
      next_st.dec = rst_st.dec;
      next_st.hist = rst_st.hist;
      next_st.bcnt = rst_st.bcnt;
      next_st.dsh = rst_st.dsh;
      next_st.crc = rst_st.crc;
      next_st.time_word = rst_st.time_word;
      next_st.crc_ok = rst_st.crc_ok;
      next_st.sync_p = rst_st.sync_p;
      next_st.div = rst_st.div;
      next_st.ref_o = rst_st.ref_o;
      next_st.rcnt = rst_st.rcnt;
      next_st.rper = rst_st.rper;
      next_st.icnt = rst_st.icnt;
      next_st.iper = rst_st.iper;
      next_st.up = rst_st.up;
      next_st.dn = rst_st.dn;
      next_st.lock = rst_st.lock;
      next_st.pos = rst_st.pos;
      next_st.neg = rst_st.neg;
      next_st.neg_oe = rst_st.neg_oe;
    end
  end

  // main state register; reset image is all constants
  always_ff @(posedge I_REF_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      st <= '0;
      st.core <= wtdhc_pkg::CORE_RST_VAL;
      st.sw_reg <= wtdhc_pkg::SWITCH_RST_VAL;
      st.msel <= wtdhc_pkg::MONITOR_RST_VAL;
      st.dec <= wtdhc_pkg::DEC_HUNT;
      st.neg_oe <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from the state register
  assign O_TIME_SYNC_OUT = st.sync_p;
  assign O_TIME_DATA = st.time_word;
  assign O_CRC_OK = st.crc_ok;
  assign O_SERVO_REF_OUT = st.ref_o;
  assign O_LOCK = st.lock;
  assign O_MOTOR_CTL_POS = st.pos;
  assign O_MOTOR_CTL_NEG = st.neg;
  assign O_MOTOR_CTL_NEG_OE = st.neg_oe;
  assign O_SW_A_OUT = st.a_out;
  assign O_SW_B_OUT = st.b_out;
  assign O_SW_B_OUT1 = st.b1_out;
  assign O_SW_B_OUT1_OE = st.b1_oe;
endmodule
`default_nettype wire

// *** wtdhc_pkg.sv ***
// constants and types shared by the wobble time decoder host control block
package wtdhc_pkg;
  // serial frame addresses, sent lsb first
  localparam logic [7:0] ADDR_CMD = 8'h7A;
  localparam logic [7:0] ADDR_OUT = 8'h7B;
  localparam int ADDR_BITS = 8;
  localparam int CMD_BITS = 8;
  localparam int OUT_BITS = 25;
  // register select nibbles
  localparam logic [3:0] SEL_CORE = 4'h0;
  localparam logic [3:0] SEL_SWITCH = 4'h1;
  localparam logic [3:0] SEL_MONITOR = 4'h8;
  // core control field positions
  localparam int CORE_SOFT_RST = 3;
  localparam int CORE_SYNC_CLR = 2;
  localparam int CORE_GUARD = 1;
  localparam int CORE_DBL = 0;
  // reset values
  localparam logic [3:0] CORE_RST_VAL = 4'h0;
  localparam logic SWITCH_RST_VAL = 1'b1;
  localparam logic [3:0] MONITOR_RST_VAL = 4'h0;
  // monitor word selections
  localparam logic [3:0] MON_STATUS = 4'h0;
  localparam logic [3:0] MON_CRC_TIME = 4'h1;
  localparam logic [3:0] MON_TIME = 4'h2;
  // time code frame shape
  localparam int TIME_BITS = 24;
  localparam int CRC_BITS = 14;
  localparam int FRAME_DATA = TIME_BITS + CRC_BITS;
  localparam int FRAME_LEN = 42;
  localparam logic [7:0] SYNC_PAT = 8'hE8;
  localparam logic [13:0] CRC_POLY = 14'h1405;
  // servo reference: half periods in 100 ns main clock cycles
  localparam int CLK_NS = 100;
  localparam int REF_HALF_NS_NORM = 22700;
  localparam int REF_HALF_NS_DBL = 11300;
  localparam int REF_HALF_NORM = REF_HALF_NS_NORM / CLK_NS;
  localparam int REF_HALF_DBL = REF_HALF_NS_DBL / CLK_NS;
  localparam int LOCK_PCT = 15;
  localparam int CNT_W = 16;
  // synchroniser slots for pin inputs
  localparam int P_BCLK = 0;
  localparam int P_BDAT = 1;
  localparam int P_CARR = 2;
  localparam int P_COARSE = 3;
  localparam int P_REF = 4;
  localparam int P_SRC = 5;
  localparam int P_STYLE = 6;
  localparam int P_SWPIN = 7;
  localparam int P_AI0 = 8;
  localparam int P_AI1 = 9;
  localparam int P_BI0 = 10;
  localparam int P_BI1 = 11;
  localparam int P_CE = 12;
  localparam int P_TOG = 13;
  localparam int NPIN = 14;
  typedef enum logic {DEC_HUNT, DEC_TRACK} wtdhc_dec_t;
endpackage

// *** wtdhc_chk.sv ***
// port-level assertion checker for the wobble time decoder host control block
`timescale 1ns/1ps
`default_nettype none
module wtdhc_chk #(
  parameter int REF_HALF_N = 8
) (
  input wire logic I_REF_CLK,
  input wire logic I_RESET_N,
  input wire logic I_CHIP_EN,
  input wire logic I_SWITCH_PIN_CTL,
  input wire logic I_SW_A_IN0,
  input wire logic I_SW_A_IN1,
  input wire logic I_SW_B_IN0,
  input wire logic I_SW_B_IN1,
  input wire logic O_SERIAL_OUT,
  input wire logic O_TIME_SYNC_OUT,
  input wire logic O_SERVO_REF_OUT,
  input wire logic O_LOCK,
  input wire logic O_SW_A_OUT,
  input wire logic O_SW_B_OUT,
  input wire logic O_SW_B_OUT1,
  input wire logic O_SW_B_OUT1_OE
);
  logic [2:0] up_cnt;
  logic [7:0] hi_run;
  // pin paths need three edges to refill after reset, so gate them until then
  always_ff @(posedge I_REF_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      up_cnt <= 3'h0;
      hi_run <= 8'h00;
    end else begin
      up_cnt <= (up_cnt == 3'h4) ? up_cnt : up_cnt + 3'h1;
      hi_run <= O_SERVO_REF_OUT ? hi_run + 8'h01 : 8'h00;
    end
  end
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RESET_N);
  a_sw_a_zero: assert property (up_cnt == 3'h4 && !$past(I_SWITCH_PIN_CTL, 3) |->
    O_SW_A_OUT == $past(I_SW_A_IN0, 3)) else $error("switch A left input 0");
  a_sw_b_zero: assert property (up_cnt == 3'h4 && !$past(I_SWITCH_PIN_CTL, 3) |->
    O_SW_B_OUT == $past(I_SW_B_IN0, 3)) else $error("switch B left input 0");
  a_sw_b1_off: assert property (up_cnt == 3'h4 && !$past(I_SWITCH_PIN_CTL, 3) |->
    !O_SW_B_OUT1_OE) else $error("second B output driven with pin low");
  a_sw_b1_pass: assert property (up_cnt == 3'h4 && O_SW_B_OUT1_OE |->
    O_SW_B_OUT1 == $past(I_SW_B_IN1, 3)) else $error("second B output wrong source");
  a_sw_in1_pass: assert property (up_cnt == 3'h4 && O_SW_B_OUT1_OE |->
    O_SW_A_OUT == $past(I_SW_A_IN1, 3) && O_SW_B_OUT == $past(I_SW_A_IN1, 3))
    else $error("switches not on input 1");
  a_sync_single: assert property (O_TIME_SYNC_OUT |=> !O_TIME_SYNC_OUT)
    else $error("sync pulse wider than one cycle");
  a_serial_idle: assert property (!I_CHIP_EN && !$past(I_CHIP_EN) |-> !O_SERIAL_OUT)
    else $error("serial output active outside a frame");
  a_ref_half_max: assert property (hi_run <= REF_HALF_N)
    else $error("reference high phase too long");
  c_sw_in1: cover property (O_SW_B_OUT1_OE);
  c_sync: cover property (O_TIME_SYNC_OUT);
  c_lock: cover property ($rose(O_LOCK));
  c_serial: cover property ($rose(O_SERIAL_OUT));
endmodule
bind wtdhc_top wtdhc_chk #(.REF_HALF_N(REF_HALF_N)) u_chk (.I_REF_CLK(I_REF_CLK),
  .I_RESET_N(I_RESET_N), .I_CHIP_EN(I_CHIP_EN), .I_SWITCH_PIN_CTL(I_SWITCH_PIN_CTL),
  .I_SW_A_IN0(I_SW_A_IN0), .I_SW_A_IN1(I_SW_A_IN1), .I_SW_B_IN0(I_SW_B_IN0),
  .I_SW_B_IN1(I_SW_B_IN1), .O_SERIAL_OUT(O_SERIAL_OUT), .O_TIME_SYNC_OUT(O_TIME_SYNC_OUT),
  .O_SERVO_REF_OUT(O_SERVO_REF_OUT), .O_LOCK(O_LOCK), .O_SW_A_OUT(O_SW_A_OUT),
  .O_SW_B_OUT(O_SW_B_OUT), .O_SW_B_OUT1(O_SW_B_OUT1), .O_SW_B_OUT1_OE(O_SW_B_OUT1_OE));
`default_nettype wire

// *** wtdhc_host_model.sv ***
// host processor model driving the serial command and readback link
`timescale 1ns/1ps
`default_nettype none
module wtdhc_host_model (
  input wire logic i_type_sel,
  input wire logic i_serial_out,
  output logic o_chip_en,
  output logic o_bit_clk,
  output logic o_serial_in
);
  initial begin
    o_chip_en = 1'b0;
    o_bit_clk = 1'b0;
    o_serial_in = 1'b0;
  end
  // one frame of address (type select high only) plus 25 link clocks, 30 ns period; the link clock idles low between frames
  task automatic frame(input logic [7:0] addr, input logic [7:0] cmd, output logic [24:0] rd);
    logic [15:0] tx;
    int off;
    tx = i_type_sel ? {cmd, addr} : {8'h00, cmd};
    off = i_type_sel ? 8 : 0;
    rd = '0;
    o_chip_en = 1'b1;
    for (int p = 0; p < off + 25; p++) begin
      // past the command the line toggles, so stray bits must be ignored
      o_serial_in = (p < off + 8) ? tx[p] : p[0];
      #14;
      if (p >= off && p - off < 25) rd[p - off] = i_serial_out;
      #1 o_bit_clk = 1'b1;
      #15 o_bit_clk = 1'b0;
    end
    #15 o_chip_en = 1'b0;
    o_serial_in = ~o_serial_in;
    #1000;
  endtask
endmodule
`default_nettype wire

// *** test_wobble_time_decoder_host_control.sv ***
// self-checking bench for the wobble time decoder host control block
`timescale 1ns/1ps
`default_nettype none
module test_wobble_time_decoder_host_control;
  localparam int HN = 8;
  localparam int HD = 4;
  localparam logic [23:0] TW = 24'hDA3C96;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic type_sel = 1'b1;
  logic bi_clk = 1'b0;
  logic bi_dat = 1'b0;
  logic car = 1'b0;
  logic crs = 1'b0;
  logic src = 1'b0;
  logic style = 1'b0;
  logic sw_pin = 1'b1;
  logic [3:0] sw_in = 4'h9;
  logic ce, bclk, sdi, sdo, sync, lock, pos, neg, a_out, b_out, b1, b1_oe, neg_oe, crc_ok;
  wire logic sref;
  logic [23:0] tdata;
  logic [24:0] rd;
  int car_half = 0;
  int car_cnt = 0;
  int sync_seen = 0;
  int fail_count = 0;
  int checks_done = 0;
  always #50 clk = ~clk;
  wtdhc_top #(.REF_HALF_N(HN), .REF_HALF_D(HD), .FRAME_LEN(42)) u_dut (
    .I_REF_CLK(clk), .I_RESET_N(rst_n), .I_IFACE_TYPE_SEL(type_sel), .I_CHIP_EN(ce),
    .I_SERIAL_BIT_CLK(bclk), .I_SERIAL_IN(sdi), .O_SERIAL_OUT(sdo), .I_BIPHASE_CLK_IN(bi_clk),
    .I_BIPHASE_DATA_IN(bi_dat), .I_CARRIER_CLK_IN(car), .I_COARSE_CLK_IN(crs),
    .I_SERVO_REF_IN(sref), .I_SERVO_SRC_SEL(src), .I_OUT_STYLE_SEL(style),
    .I_SWITCH_PIN_CTL(sw_pin), .I_SW_A_IN0(sw_in[0]), .I_SW_A_IN1(sw_in[1]), .I_SW_B_IN0(sw_in[2]),
    .I_SW_B_IN1(sw_in[3]), .O_TIME_SYNC_OUT(sync), .O_TIME_DATA(tdata), .O_CRC_OK(crc_ok),
    .O_SERVO_REF_OUT(sref), .O_LOCK(lock), .O_MOTOR_CTL_POS(pos), .O_MOTOR_CTL_NEG(neg),
    .O_MOTOR_CTL_NEG_OE(neg_oe), .O_SW_A_OUT(a_out), .O_SW_B_OUT(b_out), .O_SW_B_OUT1(b1),
    .O_SW_B_OUT1_OE(b1_oe));
  wtdhc_host_model u_host (.i_type_sel(type_sel), .i_serial_out(sdo), .o_chip_en(ce),
    .o_bit_clk(bclk), .o_serial_in(sdi));
  // carrier toggles every car_half cycles; coarse input runs far too fast on purpose
  always @(posedge clk) begin
    car_cnt <= (car_cnt + 1 >= car_half) ? 0 : car_cnt + 1;
    if (car_half != 0 && car_cnt + 1 >= car_half)
      car <= #1 ~car;
    crs <= #1 ~crs;
    if (sync === 1'b1)
      sync_seen++;
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // bounded wait on lock (0), pos (1) or neg (2)
  task automatic wait_on(input int w, input logic v);
    int n;
    n = 0;
    while ((w == 0 ? lock : (w == 1 ? pos : neg)) !== v && n < 600) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n == 600) begin
      fail_count++;
      tally_and_finish();
    end
  endtask
  task automatic xfer(input logic [7:0] a, input logic [7:0] c);
    u_host.frame(a, c, rd);
    @(posedge clk);
    #1;
  endtask
  task automatic settle();
    repeat (4) @(posedge clk);
    #1;
  endtask
  task automatic bi_bit(input logic b);
    bi_dat = b;
    repeat (2) @(posedge clk);
    #1 bi_clk = 1'b1;
    repeat (2) @(posedge clk);
    #1 bi_clk = 1'b0;
  endtask
  // check bits of a word: remainder of the word times x^14 by the package polynomial
  function automatic logic [13:0] crc_of(input logic [23:0] d);
    logic [13:0] r;
    r = 14'h0000;
    for (int i = 23; i >= 0; i--)
      r = {r[12:0], 1'b0} ^ ((d[i] ^ r[13]) ? wtdhc_pkg::CRC_POLY : 14'h0000);
    return r;
  endfunction
  // sync first, word and check bits msb first; idle ones so no false sync can form
  task automatic bi_frame(input int fill);
    logic [45:0] s;
    s = {wtdhc_pkg::SYNC_PAT, TW, crc_of(TW)};
    for (int i = 45; i >= 0; i--)
      bi_bit(s[i]);
    for (int i = 0; i < fill; i++)
      bi_bit(1'b1);
  endtask
  // pos highs, neg driven high and neg driven low over 64 cycles after settling
  task automatic style_counts(output int p_hi, output int n_hi, output int n_lo);
    p_hi = 0;
    n_hi = 0;
    n_lo = 0;
    repeat (100) @(posedge clk);
    #1;
    for (int i = 0; i < 64; i++) begin
      p_hi += (pos === 1'b1) ? 1 : 0;
      n_hi += (neg_oe === 1'b1 && neg === 1'b1) ? 1 : 0;
      n_lo += (neg_oe === 1'b1 && neg === 1'b0) ? 1 : 0;
      @(posedge clk);
      #1;
    end
  endtask
  // error-signal style: slow input first, then fast input, against the double speed reference
  task automatic t_style();
    int p_hi;
    int n_hi;
    int n_lo;
    check_val(neg_oe, 1'b1);
    style = 1'b1;
    car_half = 4 * HD;
    style_counts(p_hi, n_hi, n_lo);
    check_val(p_hi < 32, 1'b1);
    check_val({n_hi > 32, n_lo == 0}, 2'h3);
    car_half = 2;
    style_counts(p_hi, n_hi, n_lo);
    check_val(p_hi > 32, 1'b1);
    check_val({n_hi == 0, n_lo > 0}, 2'h3);
    style = 1'b0;
  endtask
  task automatic t_reset_state();
    check_val(a_out, 1'b0);
    check_val({b1_oe, b1}, 2'h3);
    xfer(8'h7B, 8'h00);
    check_val(rd, 25'h0000000);
  endtask
  task automatic t_switch();
    xfer(8'h7A, 8'h10);
    check_val({a_out, b1_oe}, 2'h2);
    xfer(8'h7C, 8'h11);
    check_val(a_out, 1'b1);
    xfer(8'h7A, 8'h11);
    check_val(a_out, 1'b0);
    sw_pin = 1'b0;
    settle();
    check_val({a_out, b1_oe}, 2'h2);
    sw_pin = 1'b1;
    settle();
  endtask
  task automatic t_soft_reset();
    int highs;
    highs = 0;
    xfer(8'h7A, 8'h08);
    xfer(8'h7B, 8'h00);
    check_val(rd, 25'h0000080);
    check_val(a_out, 1'b0);
    // the reference divider must stay frozen while soft reset is held
    for (int i = 0; i < 20; i++) begin
      @(posedge clk);
      highs += (sref === 1'b0) ? 0 : 1;
    end
    #1;
    check_val(highs, 0);
    xfer(8'h7A, 8'h00);
    xfer(8'h7B, 8'h00);
    check_val(rd[7:0], 8'h00);
  endtask
  task automatic t_time_code();
    sync_seen = 0;
    bi_frame(8);
    check_val(tdata, TW);
    check_val(crc_ok, 1'b1);
    check_val(sync_seen, 1);
    xfer(8'h7A, 8'h02);
    sync_seen = 0;
    bi_frame(8);
    check_val(sync_seen, 2);
    xfer(8'h7A, 8'h82);
    xfer(8'h7B, 8'h00);
    check_val(rd, {1'b0, TW});
    xfer(8'h7A, 8'h81);
    xfer(8'h7B, 8'h00);
    check_val(rd, {TW, 1'b1});
    xfer(8'h7A, 8'h04);
    sync_seen = 0;
    bi_frame(8);
    check_val(sync_seen, 0);
    xfer(8'h7A, 8'h00);
    type_sel = 1'b0;
    xfer(8'h00, 8'h82);
    xfer(8'h00, 8'h82);
    check_val(rd, {1'b0, TW});
    type_sel = 1'b1;
  endtask
  task automatic t_servo();
    car_half = HN;
    wait_on(0, 1'b1);
    check_val(lock, 1'b1);
    src = 1'b1;
    wait_on(0, 1'b0);
    wait_on(2, 1'b1);
    check_val({pos, lock}, 2'h0);
    src = 1'b0;
    wait_on(0, 1'b1);
    car_half = 2 * HN;
    wait_on(0, 1'b0);
    wait_on(1, 1'b1);
    check_val({neg, lock}, 2'h0);
    xfer(8'h7A, 8'h01);
    car_half = HD;
    wait_on(0, 1'b1);
    check_val(lock, 1'b1);
  endtask
  initial begin
    repeat (12) @(posedge clk);
    #1 rst_n = 1'b1;
    settle();
    t_reset_state();
    t_switch();
    t_soft_reset();
    t_time_code();
    t_servo();
    t_style();
    tally_and_finish();
  end
endmodule
`default_nettype wire
